// >>> verilog/gcs_defines.svh
// Offsets, field positions, masks and reset values of the register bank
`ifndef GCS_DEFINES_SVH
`define GCS_DEFINES_SVH

// Register indices, byte address is four times the index
`define GCS_IDX_PATH 8'h11
`define GCS_IDX_FILT 8'h12
`define GCS_IDX_ORNT 8'h13
`define GCS_IDX_SRC 8'h14
`define GCS_IDX_TMPL 8'h15
`define GCS_IDX_TMPH 8'h16
`define GCS_IDX_STAT 8'h17
`define GCS_IDX_PRL 8'h18
`define GCS_IDX_PRH 8'h19
`define GCS_IDX_RRL 8'h1A
`define GCS_IDX_RRH 8'h1B
`define GCS_IDX_YRL 8'h1C
`define GCS_IDX_YRH 8'h1D
`define GCS_IDX_CTL4 8'h1E
`define GCS_IDX_NONE 8'hFF

// Writable bits, reserved bits are dropped and read as zero
`define GCS_MASK_PATH 8'h0F
`define GCS_MASK_FILT 8'hCF
`define GCS_MASK_ORNT 8'h3F
`define GCS_MASK_CTL4 8'h3B

// Reset values
`define GCS_RST_PATH 8'h00
`define GCS_RST_FILT 8'h00
`define GCS_RST_ORNT 8'h00
`define GCS_RST_CTL4 8'h38

// Field positions
`define GCS_POS_INT_SEL 2
`define GCS_POS_OUT_SEL 0
`define GCS_POS_LOW_PWR 7
`define GCS_POS_HPF_ON 6
`define GCS_POS_CUTOFF 0
`define GCS_POS_PSIGN 5
`define GCS_POS_RSIGN 4
`define GCS_POS_YSIGN 3
`define GCS_POS_ORIENT 0
`define GCS_POS_YEN 5
`define GCS_POS_REN 4
`define GCS_POS_PEN 3
`define GCS_POS_LATCH 1
`define GCS_POS_FOURD 0
`define GCS_POS_IRQ_ACT 6
`define GCS_POS_ST_ACC 6
`define GCS_POS_ST_GYR 5
`define GCS_POS_ST_INACTIVITY_FLAG 4
`define GCS_POS_ST_BOOT 3
`define GCS_POS_ST_TDA 2
`define GCS_POS_ST_GDA 1
`define GCS_POS_ST_ACCEL_NEW_FLAG 0

// Highest defined cutoff code
`define GCS_CUTOFF_MAX 4'h9

`endif

// >>> verilog/gcs_pkg.sv
// State types of the register bank modules
package gcs_pkg;

  typedef struct packed {
    logic [7:0] path;
    logic [7:0] filt;
    logic [7:0] ornt;
    logic [7:0] ctl4;
    logic [5:0] src;
    logic acc_flag;
    logic [11:0] temp;
    logic [7:0] rdata;
    logic slverr;
    logic [2:0] seen;
  } gcs_regs_t;

  typedef struct packed {
    logic [15:0] rate;
  } gcs_rate_t;

  typedef struct packed {
    logic flag;
  } gcs_flag_t;

endpackage

// >>> verilog/gcs_new_flag.sv
// New-data flag, set by a sample, cleared by a read
`timescale 1ns/100ps
module gcs_new_flag (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Events
  input wire logic set_pulse,
  input wire logic clr_pulse,
  // Flag
  output logic flag
);

  gcs_pkg::gcs_flag_t s_reg;
  gcs_pkg::gcs_flag_t s_next;

  always_comb begin
    s_next = s_reg;
    if (clr_pulse) begin
      s_next.flag = 1'b0;
    end
    if (set_pulse) begin
      s_next.flag = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign flag = s_reg.flag;

endmodule

// >>> verilog/gcs_rate_chan.sv
// One angular rate channel with sign and output enable
`timescale 1ns/100ps
module gcs_rate_chan (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Sample
  input wire logic sample_valid,
  input wire logic [15:0] raw_rate,
  // Settings
  input wire logic sign_invert,
  input wire logic out_enable,
  // Output word
  output logic [15:0] rate
);

  gcs_pkg::gcs_rate_t s_reg;
  gcs_pkg::gcs_rate_t s_next;

  always_comb begin
    s_next = s_reg;
    if (sample_valid && out_enable) begin
      if (sign_invert) begin
        s_next.rate = 16'(~raw_rate + 16'h0001);
      end else begin
        s_next.rate = raw_rate;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rate = s_reg.rate;

endmodule

// >>> verilog/gcs_regs.sv
// Gyroscope configuration and status register bank on APB
//
// Behaviour
// - Two 2-bit path selects, reset 00.
// - Low-power bit resets 0, 1 enables.
// - High-pass on bit resets 0, 1 inserts.
// - Cutoff code resets 0000, codes 0000-1001.
// - Cutoff scales with data rate, indicative.
// - Axis sign bits reset 0, 1 negates.
// - Orientation select 3 bits, reset 000.
// - Interrupt-active reads 1 on any event.
// - Six axis event flags, top bit zero.
// - Temperature word, low 15h, high 16h.
// - Temperature sign fills five upper bits.
// - Status irq flags, bit 7 zero.
// - Boot flag reads 1 while booting.
// - Temperature new-data flag on new sample.
// - Gyro and accel new-data flags, reset 0.
// - Rate words at 18h, 1Ah, 1Ch.
// - Axis output enables reset 1.
// - Accel irq latch bit, reset 0.
// - Accel four-direction option, reset 0.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/100ps
`include "gcs_defines.svh"
module gcs_regs (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Temperature sample
  input wire logic temp_valid,
  input wire logic [11:0] temp_sample,
  // Gyroscope sample
  input wire logic gyro_valid,
  input wire logic [15:0] pitch_raw,
  input wire logic [15:0] roll_raw,
  input wire logic [15:0] yaw_raw,
  // Accelerometer data events
  input wire logic accel_valid,
  input wire logic accel_data_read,
  // Interrupt events and status inputs
  input wire logic [5:0] gyro_events,
  input wire logic accel_irq_event,
  input wire logic inactivity_in,
  input wire logic boot_running,
  // Filter path settings
  output logic [1:0] int_path_sel,
  output logic [1:0] out_path_sel,
  output logic gyro_low_power,
  output logic gyro_hpf_on,
  output logic [3:0] gyro_hpf_cutoff,
  // Sign and orientation settings
  output logic pitch_sign_invert,
  output logic roll_sign_invert,
  output logic yaw_sign_invert,
  output logic [2:0] user_orient,
  // Axis enables and accel interrupt options
  output logic pitch_out_en,
  output logic roll_out_en,
  output logic yaw_out_en,
  output logic accel_irq_latch,
  output logic accel_four_dir_option,
  // Interrupt summary
  output logic gyro_irq_active
);

  gcs_pkg::gcs_regs_t s_reg;
  gcs_pkg::gcs_regs_t s_next;

  logic setup;
  logic acc;
  logic wr;
  logic rd;
  logic [7:0] idx;
  logic [7:0] rbyte;
  logic [7:0] wbyte;
  logic [15:0] pitch_rate;
  logic [15:0] roll_rate;
  logic [15:0] yaw_rate;
  logic temp_new_flag;
  logic gyro_new_flag;
  logic accel_new_flag;
  logic accel_irq_flag;
  logic gyro_irq_flag;
  logic inactivity_flag;
  logic [7:0] status_byte;
  logic [7:0] src_byte;
  logic [7:0] temp_high;
  logic temp_rd;
  logic gyro_rd;
  logic src_rd;
  logic stat_rd;

  // Word-aligned address to register index
  function automatic logic [7:0] gcs_decode(input logic [7:0] addr);
    logic [7:0] i;
    i = {2'b00, addr[7:2]};
    if (addr[1:0] != 2'b00) begin
      gcs_decode = `GCS_IDX_NONE;
    end else if (i < `GCS_IDX_PATH) begin
      gcs_decode = `GCS_IDX_NONE;
    end else if (i > `GCS_IDX_CTL4) begin
      gcs_decode = `GCS_IDX_NONE;
    end else begin
      gcs_decode = i;
    end
  endfunction

  // Bus phases, the slave never inserts wait states
  assign setup = psel && !penable;
  assign acc = psel && penable;
  assign wr = acc && pwrite && pstrb[0];
  assign rd = acc && !pwrite;
  assign idx = gcs_decode(paddr);
  assign wbyte = pwdata[7:0];

  // Read clears act on the completing access
  assign temp_rd = rd && (idx == `GCS_IDX_TMPL || idx == `GCS_IDX_TMPH);
  assign gyro_rd = rd && idx >= `GCS_IDX_PRL && idx <= `GCS_IDX_YRH;
  assign src_rd = rd && idx == `GCS_IDX_SRC;
  assign stat_rd = rd && idx == `GCS_IDX_STAT;

  // Interrupt summaries
  assign gyro_irq_active = |s_reg.src;
  assign gyro_irq_flag = gyro_irq_active;
  assign accel_irq_flag = s_reg.acc_flag;
  assign inactivity_flag = inactivity_in;

  // Source byte, top bit zero
  assign src_byte = {1'b0, gyro_irq_active, s_reg.src};

  // Status byte, bit 7 zero
  always_comb begin
    status_byte = 8'h00;
    status_byte[`GCS_POS_ST_ACC] = accel_irq_flag;
    status_byte[`GCS_POS_ST_GYR] = gyro_irq_flag;
    status_byte[`GCS_POS_ST_INACTIVITY_FLAG] = inactivity_flag;
    status_byte[`GCS_POS_ST_BOOT] = boot_running;
    status_byte[`GCS_POS_ST_TDA] = temp_new_flag;
    status_byte[`GCS_POS_ST_GDA] = gyro_new_flag;
    status_byte[`GCS_POS_ST_ACCEL_NEW_FLAG] = accel_new_flag;
  end

  // Sign-extended temperature high byte
  assign temp_high = {{5{s_reg.temp[11]}}, s_reg.temp[10:8]};

  // Read data selection
  always_comb begin
    rbyte = 8'h00;
    if (idx == `GCS_IDX_PATH) begin
      rbyte = s_reg.path;
    end else if (idx == `GCS_IDX_FILT) begin
      rbyte = s_reg.filt;
    end else if (idx == `GCS_IDX_ORNT) begin
      rbyte = s_reg.ornt;
    end else if (idx == `GCS_IDX_SRC) begin
      rbyte = src_byte;
    end else if (idx == `GCS_IDX_TMPL) begin
      rbyte = s_reg.temp[7:0];
    end else if (idx == `GCS_IDX_TMPH) begin
      rbyte = temp_high;
    end else if (idx == `GCS_IDX_STAT) begin
      rbyte = status_byte;
    end else if (idx == `GCS_IDX_PRL) begin
      rbyte = pitch_rate[7:0];
    end else if (idx == `GCS_IDX_PRH) begin
      rbyte = pitch_rate[15:8];
    end else if (idx == `GCS_IDX_RRL) begin
      rbyte = roll_rate[7:0];
    end else if (idx == `GCS_IDX_RRH) begin
      rbyte = roll_rate[15:8];
    end else if (idx == `GCS_IDX_YRL) begin
      rbyte = yaw_rate[7:0];
    end else if (idx == `GCS_IDX_YRH) begin
      rbyte = yaw_rate[15:8];
    end else if (idx == `GCS_IDX_CTL4) begin
      rbyte = s_reg.ctl4;
    end else begin
      rbyte = 8'h00;
    end
  end

  // Next state
  always_comb begin
    s_next = s_reg;
    // Snapshot read data and flags in the setup cycle
    if (setup) begin
      s_next.rdata = rbyte;
      s_next.slverr = idx == `GCS_IDX_NONE;
      s_next.seen = {temp_new_flag, gyro_new_flag, accel_new_flag};
    end
    // Control writes, reserved bits forced to zero
    if (wr && idx == `GCS_IDX_PATH) begin
      s_next.path = wbyte & `GCS_MASK_PATH;
    end
    if (wr && idx == `GCS_IDX_FILT) begin
      s_next.filt = wbyte & `GCS_MASK_FILT;
      if (wbyte[3:0] > `GCS_CUTOFF_MAX) begin
        s_next.filt[3:0] = s_reg.filt[3:0];
      end
    end
    if (wr && idx == `GCS_IDX_ORNT) begin
      s_next.ornt = wbyte & `GCS_MASK_ORNT;
    end
    if (wr && idx == `GCS_IDX_CTL4) begin
      s_next.ctl4 = wbyte & `GCS_MASK_CTL4;
    end
    // Gyro event flags, a new event wins over the read clear
    if (src_rd) begin
      s_next.src = s_reg.src & ~s_reg.rdata[5:0];
    end
    s_next.src = s_next.src | gyro_events;
    // Accel interrupt flag, sticky only when latched
    if (s_reg.ctl4[`GCS_POS_LATCH]) begin
      if (stat_rd && s_reg.rdata[`GCS_POS_ST_ACC]) begin
        s_next.acc_flag = 1'b0;
      end
      if (accel_irq_event) begin
        s_next.acc_flag = 1'b1;
      end
    end else begin
      s_next.acc_flag = accel_irq_event;
    end
    // Temperature sample capture
    if (temp_valid) begin
      s_next.temp = temp_sample;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg.path <= `GCS_RST_PATH;
      s_reg.filt <= `GCS_RST_FILT;
      s_reg.ornt <= `GCS_RST_ORNT;
      s_reg.ctl4 <= `GCS_RST_CTL4;
      s_reg.src <= 6'h00;
      s_reg.acc_flag <= 1'b0;
      s_reg.temp <= 12'h000;
      s_reg.rdata <= 8'h00;
      s_reg.slverr <= 1'b0;
      s_reg.seen <= 3'h0;
    end else begin
      s_reg <= s_next;
    end
  end

  // New-data flags
  gcs_new_flag u_temp_flag (
    .pclk(pclk),
    .presetn(presetn),
    .set_pulse(temp_valid),
    .clr_pulse(temp_rd && s_reg.seen[2]),
    .flag(temp_new_flag)
  );

  gcs_new_flag u_gyro_flag (
    .pclk(pclk),
    .presetn(presetn),
    .set_pulse(gyro_valid),
    .clr_pulse(gyro_rd && s_reg.seen[1]),
    .flag(gyro_new_flag)
  );

  gcs_new_flag u_accel_flag (
    .pclk(pclk),
    .presetn(presetn),
    .set_pulse(accel_valid),
    .clr_pulse(accel_data_read),
    .flag(accel_new_flag)
  );

  // Angular rate channels
  gcs_rate_chan u_pitch (
    .pclk(pclk),
    .presetn(presetn),
    .sample_valid(gyro_valid),
    .raw_rate(pitch_raw),
    .sign_invert(pitch_sign_invert),
    .out_enable(pitch_out_en),
    .rate(pitch_rate)
  );

  gcs_rate_chan u_roll (
    .pclk(pclk),
    .presetn(presetn),
    .sample_valid(gyro_valid),
    .raw_rate(roll_raw),
    .sign_invert(roll_sign_invert),
    .out_enable(roll_out_en),
    .rate(roll_rate)
  );

  gcs_rate_chan u_yaw (
    .pclk(pclk),
    .presetn(presetn),
    .sample_valid(gyro_valid),
    .raw_rate(yaw_raw),
    .sign_invert(yaw_sign_invert),
    .out_enable(yaw_out_en),
    .rate(yaw_rate)
  );

  // APB answers, no wait states
  assign pready = 1'b1;
  assign prdata = {24'h000000, s_reg.rdata};
  assign pslverr = acc && s_reg.slverr;

  // Filter path settings
  assign int_path_sel = s_reg.path[`GCS_POS_INT_SEL +: 2];
  assign out_path_sel = s_reg.path[`GCS_POS_OUT_SEL +: 2];
  assign gyro_low_power = s_reg.filt[`GCS_POS_LOW_PWR];
  assign gyro_hpf_on = s_reg.filt[`GCS_POS_HPF_ON];
  // Cutoff code scaled by the filter against its data rate
  assign gyro_hpf_cutoff = s_reg.filt[`GCS_POS_CUTOFF +: 4];

  // Sign and orientation
  assign pitch_sign_invert = s_reg.ornt[`GCS_POS_PSIGN];
  assign roll_sign_invert = s_reg.ornt[`GCS_POS_RSIGN];
  assign yaw_sign_invert = s_reg.ornt[`GCS_POS_YSIGN];
  assign user_orient = s_reg.ornt[`GCS_POS_ORIENT +: 3];

  // Axis enables and accel options
  assign pitch_out_en = s_reg.ctl4[`GCS_POS_PEN];
  assign roll_out_en = s_reg.ctl4[`GCS_POS_REN];
  assign yaw_out_en = s_reg.ctl4[`GCS_POS_YEN];
  assign accel_irq_latch = s_reg.ctl4[`GCS_POS_LATCH];
  assign accel_four_dir_option = s_reg.ctl4[`GCS_POS_FOURD];

endmodule

// >>> verif/gcs_regs_properties.sv
// Concurrent checks on the ports of the register bank
`timescale 1ns/100ps
module gcs_regs_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  // Events
  input wire logic [5:0] gyro_events,
  // Settings
  input wire logic gyro_low_power,
  input wire logic gyro_hpf_on,
  input wire logic [3:0] gyro_hpf_cutoff,
  input wire logic pitch_sign_invert,
  input wire logic roll_sign_invert,
  input wire logic yaw_sign_invert,
  input wire logic [2:0] user_orient,
  input wire logic pitch_out_en,
  input wire logic roll_out_en,
  input wire logic yaw_out_en,
  input wire logic accel_irq_latch,
  input wire logic accel_four_dir_option,
  input wire logic gyro_irq_active
);
  wire logic wr = psel && penable && pwrite && pstrb[0];
  wire logic rd = psel && penable && !pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_reset_axes: assert property ($rose(presetn)
    |-> pitch_out_en && roll_out_en && yaw_out_en && !accel_irq_latch
    && !accel_four_dir_option && !pitch_sign_invert && user_orient == 3'h0)
    else $error("axis settings not at reset value");
  chk_filt_write: assert property (wr && paddr == 8'h48
    && pwdata[3:0] <= 4'h9 |=> gyro_hpf_cutoff == $past(pwdata[3:0])
    && gyro_hpf_on == $past(pwdata[6]) && gyro_low_power == $past(pwdata[7]))
    else $error("filter write not applied");
  chk_cutoff_keep: assert property (wr && paddr == 8'h48
    && pwdata[3:0] > 4'h9 |=> $stable(gyro_hpf_cutoff))
    else $error("undefined cutoff code taken");
  chk_cutoff_max: assert property (gyro_hpf_cutoff <= 4'h9)
    else $error("cutoff code out of range");
  chk_orient_write: assert property (wr && paddr == 8'h4C |=>
    {pitch_sign_invert, roll_sign_invert, yaw_sign_invert, user_orient}
    == $past(pwdata[5:0]))
    else $error("orientation write not applied");
  chk_ctl4_write: assert property (wr && paddr == 8'h78 |=>
    {yaw_out_en, roll_out_en, pitch_out_en} == $past(pwdata[5:3])
    && {accel_irq_latch, accel_four_dir_option} == $past(pwdata[1:0]))
    else $error("control four write not applied");
  chk_irq_active: assert property (gyro_events != 6'h00
    |=> gyro_irq_active)
    else $error("interrupt active not set by event");
  chk_top_bit_zero: assert property (rd && (paddr == 8'h50
    || paddr == 8'h5C) |-> prdata[7] == 1'b0)
    else $error("top bit of flag register set");
endmodule

bind gcs_regs gcs_regs_checker u_chk (.*);

// >>> verif/gcs_regs_test.sv
// Self-checking bench of the register bank
`timescale 1ns/100ps
module gcs_regs_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic temp_valid, gyro_valid, accel_valid, accel_data_read;
  logic accel_irq_event, inactivity_in, boot_running, gyro_irq_active;
  logic [11:0] temp_sample;
  logic [15:0] pitch_raw, roll_raw, yaw_raw;
  logic [5:0] gyro_events;
  logic [1:0] int_path_sel, out_path_sel;
  logic gyro_low_power, gyro_hpf_on, pitch_sign_invert, roll_sign_invert;
  logic yaw_sign_invert, pitch_out_en, roll_out_en, yaw_out_en;
  logic accel_irq_latch, accel_four_dir_option;
  logic [3:0] gyro_hpf_cutoff;
  logic [2:0] user_orient;
  int failures, checks;
  logic err_seen;

  gcs_regs u_dut (.*);

  always #4 pclk = ~pclk;

  task automatic cmp(input string nm, input logic [15:0] e,
      input logic [15:0] s);
    checks++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic w,
      input logic [7:0] d, output logic [7:0] q);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata[7:0];
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    apb(a, 1'b1, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e,
      input string nm);
    logic [7:0] q;
    apb(a, 1'b0, 8'h00, q);
    cmp(nm, {8'h00, e}, {8'h00, q});
  endtask

  task automatic test_reset;
    rd(8'h44, 8'h00, "path");
    rd(8'h48, 8'h00, "filter");
    rd(8'h4C, 8'h00, "orient");
    rd(8'h50, 8'h00, "source");
    rd(8'h5C, 8'h00, "status");
    rd(8'h78, 8'h38, "ctrl4");
    cmp("slverr", 16'h0000, {15'h0000, err_seen});
    rd(8'h40, 8'h00, "unmapped");
    cmp("slverr", 16'h0001, {15'h0000, err_seen});
    rd(8'h45, 8'h00, "unaligned");
    cmp("slverr", 16'h0001, {15'h0000, err_seen});
    $display("reset test done");
  endtask

  task automatic test_config;
    wr(8'h44, 8'h0E);
    rd(8'h44, 8'h0E, "path");
    cmp("sel", 16'h0032, {10'h000, int_path_sel, 2'h0, out_path_sel});
    pstrb <= 4'h0;
    wr(8'h44, 8'h05);
    pstrb <= 4'hF;
    rd(8'h44, 8'h0E, "no strobe");
    for (int c = 0; c < 10; c++) begin
      wr(8'h48, c[7:0]);
      cmp("cutoff", c[15:0], {12'h000, gyro_hpf_cutoff});
    end
    wr(8'h48, 8'hC9);
    rd(8'h48, 8'hC9, "filter");
    cmp("filt", 16'h00C9, {8'h00, gyro_low_power, gyro_hpf_on,
      2'h0, gyro_hpf_cutoff});
    wr(8'h48, 8'h4A);
    rd(8'h48, 8'h49, "bad code");
    wr(8'h4C, 8'h3D);
    rd(8'h4C, 8'h3D, "orient");
    cmp("orient out", 16'h003D, {10'h000, pitch_sign_invert,
      roll_sign_invert, yaw_sign_invert, user_orient});
    wr(8'h78, 8'h03);
    rd(8'h78, 8'h03, "ctrl4");
    cmp("ctrl4 out", 16'h0003, {11'h000, pitch_out_en,
      roll_out_en, yaw_out_en, accel_irq_latch, accel_four_dir_option});
    $display("config test done");
  endtask

  task automatic temp_case(input logic [11:0] t, input logic [7:0] lo,
      input logic [7:0] hi);
    temp_sample <= t;
    temp_valid <= 1'b1;
    @(posedge pclk);
    temp_valid <= 1'b0;
    @(posedge pclk);
    rd(8'h5C, 8'h04, "temp new");
    rd(8'h54, lo, "temp low");
    rd(8'h58, hi, "temp high");
    rd(8'h5C, 8'h00, "temp cleared");
    $display("temperature test done");
  endtask

  task automatic gyro_set(input logic [15:0] p, input logic [15:0] r,
      input logic [15:0] y);
    pitch_raw <= p;
    roll_raw <= r;
    yaw_raw <= y;
    gyro_valid <= 1'b1;
    @(posedge pclk);
    gyro_valid <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic test_rates;
    wr(8'h4C, 8'h20);
    wr(8'h78, 8'h38);
    gyro_set(16'h1234, 16'h8001, 16'h7FFF);
    rd(8'h5C, 8'h02, "gyro new");
    rd(8'h60, 8'hCC, "pitch low");
    rd(8'h64, 8'hED, "pitch high");
    rd(8'h68, 8'h01, "roll low");
    rd(8'h6C, 8'h80, "roll high");
    rd(8'h70, 8'hFF, "yaw low");
    rd(8'h74, 8'h7F, "yaw high");
    rd(8'h5C, 8'h00, "gyro cleared");
    wr(8'h78, 8'h28);
    gyro_set(16'h1111, 16'h1111, 16'h1111);
    rd(8'h60, 8'hEF, "pitch low");
    rd(8'h6C, 8'h80, "roll held");
    rd(8'h74, 8'h11, "yaw high");
    $display("rate test done");
  endtask

  task automatic test_events;
    gyro_events <= 6'h25;
    accel_irq_event <= 1'b1;
    boot_running <= 1'b1;
    inactivity_in <= 1'b1;
    accel_valid <= 1'b1;
    @(posedge pclk);
    gyro_events <= 6'h00;
    accel_valid <= 1'b0;
    @(posedge pclk);
    cmp("active", 16'h0001, {15'h0000, gyro_irq_active});
    rd(8'h5C, 8'h79, "status");
    rd(8'h50, 8'h65, "source");
    rd(8'h50, 8'h00, "source");
    cmp("active", 16'h0000, {15'h0000, gyro_irq_active});
    accel_irq_event <= 1'b0;
    boot_running <= 1'b0;
    inactivity_in <= 1'b0;
    accel_data_read <= 1'b1;
    @(posedge pclk);
    accel_data_read <= 1'b0;
    @(posedge pclk);
    rd(8'h5C, 8'h00, "status");
    wr(8'h78, 8'h3A);
    accel_irq_event <= 1'b1;
    @(posedge pclk);
    accel_irq_event <= 1'b0;
    repeat (2) @(posedge pclk);
    rd(8'h5C, 8'h40, "latched");
    rd(8'h5C, 8'h00, "unlatched");
    $display("event test done");
  endtask

  task automatic complete_run;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    pstrb = 4'hF;
    {psel, penable, pwrite, temp_valid, gyro_valid, accel_valid} = '0;
    {accel_data_read, accel_irq_event, inactivity_in, boot_running} = '0;
    {paddr, pwdata, temp_sample, pitch_raw, roll_raw, yaw_raw} = '0;
    gyro_events = 6'h00;
    failures = 0;
    checks = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    test_reset;
    test_config;
    temp_case(12'h9AB, 8'hAB, 8'hF9);
    temp_case(12'h123, 8'h23, 8'h01);
    test_rates;
    test_events;
    complete_run;
  end

  initial begin
    repeat (5000) @(posedge pclk);
    failures++;
    complete_run;
  end
endmodule
